// File: dv/line_unit_regs_props.sv
// Concurrent checks on the ports of the line unit register bank.
`timescale 1ns/1ps
module line_unit_regs_props (
   input wire logic                       ref_clk,                       // Clock.
   input wire logic                       sys_rst,                       // Sync reset, high.
   input wire logic                       psel,                          // APB select.
   input wire logic                       penable,                       // APB access phase.
   input wire logic                       pwrite,                        // APB write.
   input wire logic [7:0]                 paddr,                         // APB address.
   input wire logic [31:0]                pwdata,                        // APB write data.
   input wire logic [31:0]                prdata,                        // APB read data.
   input wire logic                       pready,                        // APB ready.
   input wire logic                       pslverr,                       // APB error.
   input wire line_unit_pkg::line_pair_t  tx_line,                       // Line out.
   input wire logic                       pattern_enable,                // Generator on.
   input wire logic [5:0]                 irq_enable,                    // Event enables.
   input wire logic                       event_request,                 // Event pending.
   input wire logic                       driver_monitor_alarm,          // Driver failure.
   input wire logic                       pattern_error_insert,          // Insert pulse.
   input wire logic                       tx_buildout_disable,           // Build-out off.
   input wire logic                       rx_equalizer_enable,           // Equalizer on.
   input wire logic                       rx_monitor_mode,               // Monitoring mode.
   input wire logic                       analog_loss_detector_disable,  // Analog off.
   input wire logic                       digital_loss_detector_disable  // Digital off.
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Completed writes to the two control registers; the effect is judged two edges later.
   logic       tx_wr;
   logic       rx_wr;
   logic [3:0] rx_bits;
   assign tx_wr   = psel && penable && pready && pwrite && paddr == 8'h10;
   assign rx_wr   = psel && penable && pready && pwrite && paddr == 8'h14;
   assign rx_bits = {pwdata[0], pwdata[1], pwdata[4], pwdata[5]};
   property p_ready_after_setup; psel && !penable |=> pready; endproperty
   a_ready_after_setup: assert property (p_ready_after_setup) else $error("ready missing");
   property p_ready_in_access; pready |-> psel && penable; endproperty
   a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
   property p_err_unmapped;
      psel && !penable && (paddr < 8'h08 || paddr > 8'h14 || paddr[1:0] != 2'b00)
      |=> pready && pslverr;
   endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
   property p_err_mapped;
      psel && !penable && paddr inside {8'h08, 8'h0c, 8'h10, 8'h14} |=> !pslverr;
   endproperty
   a_err_mapped: assert property (p_err_mapped) else $error("spurious error");
   property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h000000; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_reset_quiet;
      $fell(sys_rst) |-> tx_line == 2'b00 && !event_request && !driver_monitor_alarm;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not reset");
   property p_insert_pulse;
      tx_wr && pwdata[4] && pattern_enable |=> pattern_error_insert ##1 !pattern_error_insert;
   endproperty
   a_insert_pulse: assert property (p_insert_pulse) else $error("bad insert pulse");
   property p_insert_cause; pattern_error_insert |-> $past(tx_wr && pattern_enable); endproperty
   a_insert_cause: assert property (p_insert_cause) else $error("stray insert");
   property p_buildout; tx_wr |-> ##2 tx_buildout_disable == $past(pwdata[0], 2); endproperty
   a_buildout: assert property (p_buildout) else $error("build-out level");
   property p_rx_ctl;
      rx_wr |-> ##2 {rx_equalizer_enable, rx_monitor_mode, analog_loss_detector_disable,
                     digital_loss_detector_disable} == $past(rx_bits, 2);
   endproperty
   a_rx_ctl: assert property (p_rx_ctl) else $error("receive control");
   property p_event_masked; irq_enable == 6'h00 |=> !event_request; endproperty
   a_event_masked: assert property (p_event_masked) else $error("masked request");
   cover property (tx_wr && pattern_enable);
   cover property (driver_monitor_alarm);
   cover property (event_request);
   cover property (pready && pslverr);
endmodule

// File: dv/tb_line_unit_status_control_regs.sv
// Self-checking bench for the line unit register bank.
`timescale 1ns/1ps
module tb_line_unit_status_control_regs;
   // Table rows: write, read back, expected error and control outputs.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rd;
      logic       err;
      logic [4:0] outs;
   } row_t;
   localparam row_t ROWS [7] = '{'{8'h10, 8'hff, 8'h37, 1'b0, 5'h10},
      '{8'h14, 8'hff, 8'h3f, 1'b0, 5'h1f}, '{8'h00, 8'h00, 8'h00, 1'b1, 5'h1f},
      '{8'h09, 8'h00, 8'h00, 1'b1, 5'h1f}, '{8'h10, 8'h00, 8'h00, 1'b0, 5'h0f},
      '{8'h14, 8'h15, 8'h15, 1'b0, 5'h0a}, '{8'h04, 8'hff, 8'h00, 1'b1, 5'h0a}};
   // Receiver conditions beside the alarm value they should give.
   localparam logic [18:0] LOSS [8] = '{{11'h400, 8'h12}, {11'h200, 8'h22}, {11'h100, 8'h04},
      {11'h082, 8'h08}, {11'h083, 8'h00}, {11'h08e, 8'h08}, {11'h0de, 8'h08}, {11'h001, 8'h00}};
   logic                      ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic                      pwrite = 1'b0, pattern_error = 1'b0, pattern_enable = 1'b0;
   logic                      mon_run = 1'b1, pready, pslverr, err, event_request;
   logic                      driver_monitor_alarm, pattern_error_insert, tx_buildout_disable;
   logic                      rx_equalizer_enable, rx_monitor_mode;
   logic                      analog_loss_detector_disable, digital_loss_detector_disable;
   logic [7:0]                paddr = 8'h00;
   logic [5:0]                irq_enable = 6'h00;
   logic [31:0]               pwdata = 32'h0, prdata, rd;
   line_unit_pkg::line_pair_t monitor_input = 2'b01, tx_line, rx_data, tx_data, rx_in;
   logic                      tx_clock_in = 1'b0, rx_recovered_clock = 1'b0;
   line_unit_pkg::rx_cond_t   rx_cond = 11'h000;
   int                        n_errors = 0, checked = 0, cycles = 0;
   line_unit_status_control_regs DUT (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .monitor_input, .tx_data, .tx_clock_in,
      .tx_line, .rx_in, .rx_recovered_clock, .rx_data, .rx_cond, .pattern_error,
      .pattern_enable, .irq_enable, .event_request, .driver_monitor_alarm, .pattern_error_insert,
      .tx_buildout_disable, .rx_equalizer_enable, .rx_monitor_mode,
      .analog_loss_detector_disable, .digital_loss_detector_disable);
   always #10 ref_clk = ~ref_clk;
   // Alternating marks keep the driver monitor satisfied; stopping them starts the quiet count.
   always @(posedge ref_clk) begin
      monitor_input <= mon_run ? ~monitor_input : 2'b00;
   end
   // The ceiling leaves room above the long saturation run.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 70000) begin
         n_errors++;
         $display("wrong value at %0t: run timed out", $time);
         end_sim();
      end
   end
   task automatic end_sim;
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request holds until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 2; i < 6; i++) rchk(8'(4 * i), 32'h0);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, ROWS[i].addr, {24'h0, ROWS[i].wdata}, rd, err);
         chk(32'(err), 32'(ROWS[i].err));
         rchk(ROWS[i].addr, {24'h0, ROWS[i].rd});
         chk(32'({tx_buildout_disable, rx_equalizer_enable, rx_monitor_mode,
                  analog_loss_detector_disable, digital_loss_detector_disable}),
             32'(ROWS[i].outs));
      end
      // Driver monitor quiet period, with only its event enabled.
      apb(1'b0, 8'h08, 32'h0, rd, err);
      irq_enable <= 6'h01;
      mon_run <= 1'b0;
      repeat (100) @(posedge ref_clk);
      chk(32'(driver_monitor_alarm), 32'h0);
      repeat (40) @(posedge ref_clk);
      chk(32'(driver_monitor_alarm), 32'h1);
      chk(32'(event_request), 32'h1);
      rchk(8'h0c, 32'h01);
      rchk(8'h08, 32'h01);
      rchk(8'h08, 32'h00);
      chk(32'(event_request), 32'h0);
      mon_run <= 1'b1;
      irq_enable <= 6'h00;
      repeat (10) @(posedge ref_clk);
      rchk(8'h08, 32'h01);
      // Receiver conditions, each set and then withdrawn; both changes raise the event unless the condition gives no alarm.
      apb(1'b1, 8'h14, 32'h0, rd, err);
      for (int i = 0; i < 8; i++) begin
         rx_cond <= LOSS[i][18:8];
         repeat (4) @(posedge ref_clk);
         rchk(8'h0c, {24'h0, LOSS[i][7:0]});
         rchk(8'h08, {24'h0, LOSS[i][7:0] & 8'h0e});
         rx_cond <= 11'h000;
         repeat (4) @(posedge ref_clk);
         rchk(8'h08, {24'h0, LOSS[i][7:0] & 8'h0e});
      end
      // Both detectors off: losses no longer count.
      apb(1'b1, 8'h14, 32'h30, rd, err);
      rx_cond <= 11'h600;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, 8'h0c, 32'h0, rd, err);
      chk(rd & 32'h02, 32'h0);
      rx_cond <= 11'h000;
      apb(1'b1, 8'h14, 32'h0, rd, err);
      // Inverted transmit clock: data on its rising edge.
      apb(1'b1, 8'h10, 32'h02, rd, err);
      tx_data <= 2'b01;
      tx_clock_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(32'(tx_line), 32'h1);
      // All-ones marks on a self-monitored line keep the alarm quiet.
      apb(1'b1, 8'h10, 32'h24, rd, err);
      tx_data <= 2'b00;
      tx_clock_in <= 1'b0;
      mon_run <= 1'b0;
      repeat (140) @(posedge ref_clk);
      chk(32'(^tx_line), 32'h1);
      chk(32'(driver_monitor_alarm), 32'h0);
      mon_run <= 1'b1;
      // Receive edges, then muting in a loss.
      rx_in <= 2'b11;
      rx_recovered_clock <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(32'(rx_data), 32'h3);
      apb(1'b1, 8'h14, 32'h08, rd, err);
      rx_in <= 2'b01;
      rx_recovered_clock <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(32'(rx_data), 32'h1);
      apb(1'b1, 8'h14, 32'h04, rd, err);
      rx_cond <= 11'h400;
      repeat (4) @(posedge ref_clk);
      chk(32'(rx_data), 32'h0);
      rx_cond <= 11'h000;
      // Error insertion, one bit error, then the counter driven to saturation.
      pattern_enable <= 1'b1;
      apb(1'b1, 8'h10, 32'h10, rd, err);
      apb(1'b0, 8'h08, 32'h0, rd, err);
      pattern_error <= 1'b1;
      @(posedge ref_clk);
      pattern_error <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rchk(8'h08, 32'h10);
      pattern_error <= 1'b1;
      repeat (65000) @(posedge ref_clk);
      rchk(8'h0c, 32'h40);
      rchk(8'h08, 32'h10);
      repeat (600) @(posedge ref_clk);
      rchk(8'h08, 32'h30);
      pattern_error <= 1'b0;
      // Mid-run reset clears the bank.
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 2; i < 6; i++) rchk(8'(4 * i), 32'h0);
      end_sim();
   end
endmodule
bind line_unit_status_control_regs line_unit_regs_props props (.ref_clk, .sys_rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_line, .pattern_enable,
   .irq_enable, .event_request, .driver_monitor_alarm, .pattern_error_insert,
   .tx_buildout_disable, .rx_equalizer_enable, .rx_monitor_mode,
   .analog_loss_detector_disable, .digital_loss_detector_disable);

// File: hw/line_unit_pkg.sv
// Constants, field layouts and carrier types for the line unit register bank.
// Notes on behaviour
// - Driver monitor change sets sticky event, read clears.
// - Signal loss change sets sticky event, read clears.
// - Lock loss change sets sticky event, read clears.
// - FIFO limit change sets sticky event, read clears.
// - Pattern bit error sets sticky event, read clears.
// - Error counter saturation sets sticky event, read clears.
// - Driver alarm after 128 pulseless bit periods.
// - Expose signal loss, analog and digital loss.
// - Expose receiver lock loss as status.
// - FIFO limit within two bits of limits.
// - Pattern error status on detected bit error.
// - Build-out bit one disables build-out circuit.
// - Clock invert samples transmit data on rising.
// - All-ones bit sends continuous marks.
// - Insert one error only when generator enabled.
// - Self monitor routes monitor to own transmitter.
// - Equalizer bit one enables receive equalizer.
// - Monitor bit selects receiver monitoring mode.
// - Mute bit grounds receive data during loss.
// - Receive invert updates data on falling edge.
// - Disable bits turn off loss detectors.
// - Events request interrupts only when enabled.
package line_unit_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_EVENT  = 8'h02;
   localparam logic [7:0] IDX_ALARM  = 8'h03;
   localparam logic [7:0] IDX_TX_CTL = 8'h04;
   localparam logic [7:0] IDX_RX_CTL = 8'h05;

   // Writable and readable field masks per register.
   localparam logic [7:0] EVENT_MASK  = 8'h3f;
   localparam logic [7:0] ALARM_MASK  = 8'h7f;
   localparam logic [7:0] TX_CTL_MASK = 8'h37;
   localparam logic [7:0] RX_CTL_MASK = 8'h3f;
   localparam logic [7:0] REG_RESET   = 8'h00;

   // Event and alarm bit positions.
   localparam int EV_DRV  = 0;
   localparam int EV_LOS  = 1;
   localparam int EV_LOL  = 2;
   localparam int EV_FIFO = 3;
   localparam int EV_PAT  = 4;
   localparam int EV_SAT  = 5;
   localparam int AL_ANALOG_SIGNAL_LOSS_STATUS = 4;
   localparam int AL_DIGITAL_SIGNAL_LOSS_STATUS = 5;
   localparam int AL_PAT  = 6;

   // Transmit control bit positions.
   localparam int TX_BUILDOUT_DIS = 0;
   localparam int TX_CLK_INV      = 1;
   localparam int TX_ALL_ONES     = 2;
   localparam int TX_ERR_INSERT   = 4;
   localparam int TX_SELF_MON     = 5;

   // Receive control bit positions.
   localparam int RX_EQ_EN      = 0;
   localparam int RX_MON_MODE   = 1;
   localparam int RX_MUTE       = 2;
   localparam int RX_CLK_INV    = 3;
   localparam int RX_ANALOG_SIGNAL_LOSS_STATUS_DIS   = 4;
   localparam int RX_DIGITAL_SIGNAL_LOSS_STATUS_DIS   = 5;

   // Timing and limits.
   localparam logic [7:0]  DRV_QUIET_BITS = 8'h80;
   localparam logic [7:0]  BIT_DIV        = 8'h01;
   localparam logic [5:0]  FIFO_MARGIN    = 6'h02;
   localparam logic [5:0]  FIFO_DEPTH_S   = 6'h10;
   localparam logic [5:0]  FIFO_DEPTH_L   = 6'h20;
   localparam logic [15:0] ERR_CNT_MAX    = 16'hffff;

   // A bipolar line or data pair.
   typedef struct packed {
      logic pos;
      logic neg;
   } line_pair_t;

   // Raw conditions declared by the receiver and jitter attenuator.
   typedef struct packed {
      logic       analog_loss;
      logic       digital_loss;
      logic       lock_loss;
      logic       ja_enable;
      logic       ja_size32;
      logic [5:0] ja_fill;
   } rx_cond_t;

endpackage

// File: hw/line_unit_status_control_regs.sv
// Status, event and control register bank of the line unit, with APB access.
`timescale 1ns/1ps
module line_unit_status_control_regs (
   input  wire logic                     ref_clk,                  // 50 MHz clock.
   input  wire logic                     sys_rst,                  // Sync reset, high.
   input  wire logic                     psel,                     // APB select.
   input  wire logic                     penable,                  // APB access phase.
   input  wire logic                     pwrite,                   // APB write.
   input  wire logic [7:0]               paddr,                    // APB byte address.
   input  wire logic [31:0]              pwdata,                   // APB write data.
   output logic [31:0]                   prdata,                   // APB read data.
   output logic                          pready,                   // APB ready.
   output logic                          pslverr,                  // APB error.
   input  wire line_unit_pkg::line_pair_t monitor_input,           // External monitor pins.
   input  wire line_unit_pkg::line_pair_t tx_data,                 // Transmit data in.
   input  wire logic                     tx_clock_in,              // Transmit clock.
   output line_unit_pkg::line_pair_t      tx_line,                 // Transmit line out.
   input  wire line_unit_pkg::line_pair_t rx_in,                   // Recovered data.
   input  wire logic                     rx_recovered_clock,       // Recovered clock.
   output line_unit_pkg::line_pair_t      rx_data,                 // Receive data out.
   input  wire line_unit_pkg::rx_cond_t   rx_cond,                 // Receiver conditions.
   input  wire logic                     pattern_error,            // Detector bit error.
   input  wire logic                     pattern_enable,           // Generator enabled.
   input  wire logic [5:0]               irq_enable,               // Per-event enables.
   output logic                          event_request,            // Enabled event pending.
   output logic                          driver_monitor_alarm,     // Driver failure.
   output logic                          pattern_error_insert,     // One-cycle insert pulse.
   output logic                          tx_buildout_disable,      // Build-out off.
   output logic                          rx_equalizer_enable,      // Equalizer on.
   output logic                          rx_monitor_mode,          // Monitoring mode.
   output logic                          analog_loss_detector_disable,  // ANALOG_SIGNAL_LOSS_STATUS off.
   output logic                          digital_loss_detector_disable  // DIGITAL_SIGNAL_LOSS_STATUS off.
);

   // Whole state of the bank, registered as one word.
   typedef struct packed {
      logic [7:0]               tx_ctl;
      logic [7:0]               rx_ctl;
      logic [5:0]               events;
      logic [6:0]               alarm;
      logic [7:0]               quiet_cnt;
      logic [7:0]               div_cnt;
      logic                     tx_clk_prev;
      logic                     rx_clk_prev;
      line_unit_pkg::line_pair_t tx_line;
      line_unit_pkg::line_pair_t rx_data;
      logic                     ones_phase;
      logic [15:0]              err_cnt;
      logic                     insert;
      logic [31:0]              prdata;
      logic                     pready;
      logic                     pslverr;
      logic                     request;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // Register index of a bus address; misaligned gives zero, out-of-range passes through unchanged.
   function automatic logic [7:0] reg_index(input logic [7:0] addr);
      logic [7:0] idx;
      idx = {2'b00, addr[7:2]};
      if (addr[1:0] != 2'b00) begin
         idx = 8'h00;
      end
      return idx;
   endfunction

   // True when the index names one of the four registers of this bank.
   function automatic logic is_mapped(input logic [7:0] idx);
      return (idx == line_unit_pkg::IDX_EVENT) || (idx == line_unit_pkg::IDX_ALARM) ||
             (idx == line_unit_pkg::IDX_TX_CTL) || (idx == line_unit_pkg::IDX_RX_CTL);
   endfunction

   // Jitter attenuator fill is within the margin of empty or full.
   function automatic logic near_limit(input line_unit_pkg::rx_cond_t c);
      logic [5:0] depth;
      depth = c.ja_size32 ? line_unit_pkg::FIFO_DEPTH_L : line_unit_pkg::FIFO_DEPTH_S;
      return c.ja_enable && ((c.ja_fill <= line_unit_pkg::FIFO_MARGIN) ||
             (c.ja_fill >= depth - line_unit_pkg::FIFO_MARGIN));
   endfunction

   logic [7:0]               idx;
   logic                     setup_phase;
   logic                     access_done;
   logic                     bit_tick;
   logic                     tx_edge;
   logic                     rx_edge;
   logic                     analog_signal_loss_status;
   logic                     digital_signal_loss_status;
   logic                     pulse_seen;
   logic [6:0]               alarm_now;
   logic [5:0]               ev_set;
   logic [5:0]               ev_clr;
   line_unit_pkg::line_pair_t mon_src;
   logic [7:0]               rd_val;

   always_comb begin
      state_next = state_reg;
      idx = reg_index(paddr);
      setup_phase = psel && !penable;
      access_done = psel && penable && state_reg.pready;

      // The bus answers with one wait-free access phase: ready is raised
      // the cycle after setup, so read data is already registered by then.
      state_next.pready = setup_phase;
      state_next.pslverr = setup_phase && !is_mapped(idx);
      if (setup_phase) begin
         rd_val = 8'h00;
         if (idx == line_unit_pkg::IDX_EVENT) begin
            rd_val = {2'b00, state_reg.events};
         end else if (idx == line_unit_pkg::IDX_ALARM) begin
            rd_val = {1'b0, state_reg.alarm};
         end else if (idx == line_unit_pkg::IDX_TX_CTL) begin
            rd_val = state_reg.tx_ctl;
         end else if (idx == line_unit_pkg::IDX_RX_CTL) begin
            rd_val = state_reg.rx_ctl;
         end
         state_next.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      end else begin
         rd_val = 8'h00;
      end

      // Control writes take effect at the access edge; reserved bits stay zero.
      state_next.insert = 1'b0;
      if (access_done && pwrite) begin
         if (idx == line_unit_pkg::IDX_TX_CTL) begin
            state_next.tx_ctl = pwdata[7:0] & line_unit_pkg::TX_CTL_MASK;
            // Insertion is a one-shot request, gated by the generator enable.
            state_next.insert = pwdata[line_unit_pkg::TX_ERR_INSERT] && pattern_enable;
         end else if (idx == line_unit_pkg::IDX_RX_CTL) begin
            state_next.rx_ctl = pwdata[7:0] & line_unit_pkg::RX_CTL_MASK;
         end
      end

      // Bit-period enable from the divider.
      bit_tick = (state_reg.div_cnt == 8'h00);
      state_next.div_cnt = bit_tick ? (line_unit_pkg::BIT_DIV - 8'h01) :
                                      (state_reg.div_cnt - 8'h01);

      // Driver monitor watches our own line or the external pins.
      mon_src = state_reg.tx_ctl[line_unit_pkg::TX_SELF_MON] ?
                state_reg.tx_line : monitor_input;
      pulse_seen = mon_src.pos || mon_src.neg;
      if (bit_tick) begin
         if (pulse_seen) begin
            state_next.quiet_cnt = 8'h00;
         end else if (state_reg.quiet_cnt < line_unit_pkg::DRV_QUIET_BITS) begin
            state_next.quiet_cnt = state_reg.quiet_cnt + 8'h01;
         end
      end

      // Loss detectors are forced quiet when disabled by software.
      analog_signal_loss_status = rx_cond.analog_loss && !state_reg.rx_ctl[line_unit_pkg::RX_ANALOG_SIGNAL_LOSS_STATUS_DIS];
      digital_signal_loss_status = rx_cond.digital_loss && !state_reg.rx_ctl[line_unit_pkg::RX_DIGITAL_SIGNAL_LOSS_STATUS_DIS];

      // Live alarm status, one register stage behind the inputs.
      alarm_now = 7'h00;
      alarm_now[line_unit_pkg::EV_DRV] =
         (state_next.quiet_cnt >= line_unit_pkg::DRV_QUIET_BITS);
      alarm_now[line_unit_pkg::EV_LOS] = analog_signal_loss_status || digital_signal_loss_status;
      alarm_now[line_unit_pkg::EV_LOL] = rx_cond.lock_loss;
      alarm_now[line_unit_pkg::EV_FIFO] = near_limit(rx_cond);
      alarm_now[line_unit_pkg::AL_ANALOG_SIGNAL_LOSS_STATUS] = analog_signal_loss_status;
      alarm_now[line_unit_pkg::AL_DIGITAL_SIGNAL_LOSS_STATUS] = digital_signal_loss_status;
      alarm_now[line_unit_pkg::AL_PAT] = pattern_error;
      state_next.alarm = alarm_now;

      // Saturating error counter; it restarts when pattern_enable is low.
      if (!pattern_enable) begin
         state_next.err_cnt = 16'h0000;
      end else if (pattern_error && (state_reg.err_cnt != line_unit_pkg::ERR_CNT_MAX)) begin
         state_next.err_cnt = state_reg.err_cnt + 16'h0001;
      end

      // Event sources: status changes, pattern errors, counter saturation.
      ev_set = 6'h00;
      ev_set[line_unit_pkg::EV_DRV] = alarm_now[0] != state_reg.alarm[0];
      ev_set[line_unit_pkg::EV_LOS] = alarm_now[1] != state_reg.alarm[1];
      ev_set[line_unit_pkg::EV_LOL] = alarm_now[2] != state_reg.alarm[2];
      ev_set[line_unit_pkg::EV_FIFO] = alarm_now[3] != state_reg.alarm[3];
      ev_set[line_unit_pkg::EV_PAT] = pattern_error;
      ev_set[line_unit_pkg::EV_SAT] =
         (state_next.err_cnt == line_unit_pkg::ERR_CNT_MAX) &&
         (state_reg.err_cnt != line_unit_pkg::ERR_CNT_MAX);

      // A read clears only the bits it reported, so an event landing between
      // setup and access is kept; a new set in the clearing cycle wins too.
      ev_clr = 6'h00;
      if (access_done && !pwrite && (idx == line_unit_pkg::IDX_EVENT)) begin
         ev_clr = state_reg.prdata[5:0];
      end
      state_next.events = (state_reg.events & ~ev_clr) | ev_set;

      // Only enabled events raise the request line.
      state_next.request = |(state_next.events & irq_enable);

      // Transmit data is taken on the falling clock edge, or rising if inverted.
      state_next.tx_clk_prev = tx_clock_in;
      tx_edge = state_reg.tx_ctl[line_unit_pkg::TX_CLK_INV] ?
                (tx_clock_in && !state_reg.tx_clk_prev) :
                (!tx_clock_in && state_reg.tx_clk_prev);
      if (tx_edge) begin
         if (state_reg.tx_ctl[line_unit_pkg::TX_ALL_ONES]) begin
            // Marks alternate polarity so the line stays bipolar.
            state_next.tx_line.pos = state_reg.ones_phase;
            state_next.tx_line.neg = !state_reg.ones_phase;
            state_next.ones_phase = !state_reg.ones_phase;
         end else begin
            state_next.tx_line = tx_data;
         end
      end

      // Receive data changes on the rising clock edge, or falling if inverted.
      state_next.rx_clk_prev = rx_recovered_clock;
      rx_edge = state_reg.rx_ctl[line_unit_pkg::RX_CLK_INV] ?
                (!rx_recovered_clock && state_reg.rx_clk_prev) :
                (rx_recovered_clock && !state_reg.rx_clk_prev);
      if (state_reg.rx_ctl[line_unit_pkg::RX_MUTE] && state_reg.alarm[line_unit_pkg::EV_LOS]) begin
         // Muting acts at once rather than waiting for a clock edge, since
         // the recovered clock may be unreliable while the signal is lost.
         state_next.rx_data = '0;
      end else if (rx_edge) begin
         state_next.rx_data = rx_in;
      end
   end

   // One register stage for the whole bank; every field clears on reset.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // All outputs are taken straight from the registered state.
   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign tx_line = state_reg.tx_line;
   assign rx_data = state_reg.rx_data;
   assign event_request = state_reg.request;
   assign driver_monitor_alarm = state_reg.alarm[line_unit_pkg::EV_DRV];
   assign pattern_error_insert = state_reg.insert;
   assign tx_buildout_disable = state_reg.tx_ctl[line_unit_pkg::TX_BUILDOUT_DIS];
   assign rx_equalizer_enable = state_reg.rx_ctl[line_unit_pkg::RX_EQ_EN];
   assign rx_monitor_mode = state_reg.rx_ctl[line_unit_pkg::RX_MON_MODE];
   assign analog_loss_detector_disable = state_reg.rx_ctl[line_unit_pkg::RX_ANALOG_SIGNAL_LOSS_STATUS_DIS];
   assign digital_loss_detector_disable = state_reg.rx_ctl[line_unit_pkg::RX_DIGITAL_SIGNAL_LOSS_STATUS_DIS];

endmodule
